// ===== tntf_framer.sv
/*
 Type B framer for the tag: transmit sequencer with write-response
 header and CRC_B, receive character assembly with CRC_B check,
 NDEF attribute block with checksum, AHB-Lite register slave and an
 INF byte FIFO. Assumes rx bits arrive one per ETU on rx_stb from an
 NRZ demodulator that also marks the frame, and that tx_bit feeds a
 BPSK subcarrier modulator.
*/
`timescale 1ns/1ps
`default_nettype none
module tntf_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp, rp, next_wp, next_rp;
  logic push, pop;

  always_comb begin
    in_ready = (wp - rp) != (AW+1)'(D);
    out_valid = wp != rp;
    out_data = mem[rp[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wp = wp + (AW+1)'(push);
    next_rp = rp + (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
    if (push) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
endmodule : tntf_fifo

//Behaviour
//- Write response: 0x09, card ID, two flags
//- Block 0 attributes, blocks 1-23 NDEF
//- Access byte: 0x00 read-only, 0x01 writable
//- Checksum equals sum of bytes 0-13
//- Start bit, 8 bits LSB first, stop
//- 106 or 212 kbps, NRZ in, BPSK out
//- SOF, data up to 256 bytes, EOF
//- PCB, INF, then 2-byte CRC_B
module tntf_framer #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rx_frame,
  input wire logic rx_stb,
  input wire logic rx_bit,
  output logic tx_bit,
  output logic tx_active
);
  // Bus state
  logic dph_wr, next_dph_wr;
  logic [7:0] dph_addr, next_dph_addr;
  logic [31:0] next_hrdata;
  tntf_pkg::tntf_ctrl_s ctrl, next_ctrl;
  logic [63:0] card_id, next_card_id;
  logic [15:0] flags, next_flags;
  logic [7:0] pcb, next_pcb;
  logic [7:0] blksel, next_blksel;
  logic [31:0] attribute_info_block [4];
  logic [31:0] next_aib [4];
  logic stall, wr_ok, start_req;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [7:0] aib_b [16];
  logic [15:0] aib_sum;
  logic aib_sum_ok, aib_rw, blk_attr, blk_ndef;

  // Transmit state
  tntf_pkg::tntf_tx_e tx_st, next_tx_st;
  tntf_pkg::tntf_seg_e seg, next_seg;
  logic [10:0] etu, next_etu;
  logic [3:0] cnt, next_cnt;
  logic [8:0] inf_cnt, next_inf_cnt;
  logic [9:0] shreg, next_shreg;
  logic [15:0] tx_crc, next_tx_crc;
  logic next_tx_bit;
  logic etu_end, char_end, inf_more;

  // Receive state
  logic rx_frame_q, next_rx_frame_q;
  logic [3:0] rcnt, next_rcnt;
  logic [7:0] rshift, next_rshift;
  logic [15:0] rx_crc, next_rx_crc;
  logic rx_ferr, next_rx_ferr;
  tntf_pkg::tntf_rxinfo_s rx_cur, next_rx_cur, rx_last, next_rx_last;
  logic rx_good, next_rx_good, rx_bad, next_rx_bad;

  tntf_fifo #(.W(8), .D(FIFO_DEPTH)) tntf_fifo_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(hwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Attribute block view and checksum
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      aib_b[i] = attribute_info_block[i/4][8*(i%4) +: 8];
    end
    aib_sum = '0;
    for (int i = 0; i <= tntf_pkg::AIB_SUM_LAST; i++) begin
      aib_sum = aib_sum + {8'h00, aib_b[i]};
    end
    aib_sum_ok = aib_sum == {aib_b[tntf_pkg::AIB_SUM_HI], aib_b[tntf_pkg::AIB_SUM_LO]};
    aib_rw = aib_b[tntf_pkg::AIB_RW_BYTE] == tntf_pkg::AIB_RW_VALUE;
    blk_attr = blksel == tntf_pkg::AIB_BLOCK;
    blk_ndef = blksel >= tntf_pkg::NDEF_FIRST && blksel <= tntf_pkg::NDEF_LAST;
  end

  // Bus slave; a full FIFO holds the write data phase
  always_comb begin
    stall = dph_wr && dph_addr == tntf_pkg::OFS_TXDATA && !fifo_in_ready;
    hreadyout = !stall;
    hresp = 1'b0;
    wr_ok = dph_wr && !stall;
    fifo_in_valid = dph_wr && dph_addr == tntf_pkg::OFS_TXDATA;
    next_dph_wr = dph_wr && stall;
    next_dph_addr = dph_addr;
    next_hrdata = hrdata;
    if (hready && hsel && htrans[1]) begin
      next_dph_wr = hwrite;
      next_dph_addr = {haddr[7:2], 2'b00};
      // Read data holds through writes until the next read
      if (!hwrite) begin
        next_hrdata = '0;
        unique case ({haddr[7:2], 2'b00})
          tntf_pkg::OFS_CTRL: next_hrdata = {29'h0, ctrl.resp_write, 1'b0, ctrl.rate212};
          tntf_pkg::OFS_STATUS: next_hrdata = {24'h0, blk_ndef, blk_attr, !fifo_in_ready,
                                               aib_rw, aib_sum_ok, rx_bad, rx_good,
                                               tx_st != tntf_pkg::TX_IDLE};
          tntf_pkg::OFS_ID_LO: next_hrdata = card_id[31:0];
          tntf_pkg::OFS_ID_HI: next_hrdata = card_id[63:32];
          tntf_pkg::OFS_FLAGS: next_hrdata = {16'h0, flags};
          tntf_pkg::OFS_PCB: next_hrdata = {24'h0, pcb};
          tntf_pkg::OFS_RXINFO: next_hrdata = {7'h0, rx_last.len, 8'h0, rx_last.pcb};
          tntf_pkg::OFS_AIBSUM: next_hrdata = {16'h0, aib_sum};
          tntf_pkg::OFS_BLKSEL: next_hrdata = {24'h0, blksel};
          default: begin
            if (haddr[7:0] >= tntf_pkg::OFS_AIB0 && haddr[7:0] <= tntf_pkg::OFS_AIB3) begin
              next_hrdata = attribute_info_block[haddr[3:2]];
            end
          end
        endcase
      end
    end
    next_ctrl = ctrl;
    next_card_id = card_id;
    next_flags = flags;
    next_pcb = pcb;
    next_blksel = blksel;
    next_aib = attribute_info_block;
    start_req = 1'b0;
    if (wr_ok) begin
      unique case (dph_addr)
        tntf_pkg::OFS_CTRL: begin
          next_ctrl = {hwdata[tntf_pkg::CTRL_RESP], hwdata[tntf_pkg::CTRL_RATE]};
          start_req = hwdata[tntf_pkg::CTRL_START];
        end
        tntf_pkg::OFS_ID_LO: next_card_id[31:0] = hwdata;
        tntf_pkg::OFS_ID_HI: next_card_id[63:32] = hwdata;
        tntf_pkg::OFS_FLAGS: next_flags = hwdata[15:0];
        tntf_pkg::OFS_PCB: next_pcb = hwdata[7:0];
        tntf_pkg::OFS_BLKSEL: next_blksel = hwdata[7:0];
        default: begin
          // read-only block keeps only its access word open
          if (dph_addr >= tntf_pkg::OFS_AIB0 && dph_addr <= tntf_pkg::OFS_AIB3 &&
              (aib_rw || dph_addr[3:2] == tntf_pkg::AIB_RW_WORD)) begin
            next_aib[dph_addr[3:2]] = hwdata;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dph_wr <= 1'b0;
      dph_addr <= '0;
      hrdata <= '0;
      ctrl <= '0;
      card_id <= '0;
      flags <= '0;
      pcb <= '0;
      blksel <= '0;
      for (int i = 0; i < 4; i++) begin
        attribute_info_block[i] <= '0;
      end
    end else begin
      dph_wr <= next_dph_wr;
      dph_addr <= next_dph_addr;
      hrdata <= next_hrdata;
      ctrl <= next_ctrl;
      card_id <= next_card_id;
      flags <= next_flags;
      pcb <= next_pcb;
      blksel <= next_blksel;
      attribute_info_block <= next_aib;
    end
  end

  // Transmit sequencer
  always_comb begin
    etu_end = etu == (ctrl.rate212 ? tntf_pkg::ETU_LAST_FAST : tntf_pkg::ETU_LAST);
    char_end = etu_end && cnt == tntf_pkg::CHAR_LAST;
    // INF capped so the field stays within 256 bytes
    inf_more = fifo_out_valid && inf_cnt < tntf_pkg::INF_MAX;
    next_tx_st = tx_st;
    next_seg = seg;
    next_etu = etu_end ? '0 : etu + 11'h001;
    next_cnt = cnt;
    next_inf_cnt = inf_cnt;
    next_shreg = shreg;
    next_tx_crc = tx_crc;
    next_tx_bit = tx_bit;
    fifo_out_ready = 1'b0;
    unique case (tx_st)
      tntf_pkg::TX_IDLE: begin
        next_etu = '0;
        next_tx_bit = 1'b1;
        // no reply after a corrupt frame
        if (start_req && !rx_bad) begin
          next_tx_st = tntf_pkg::TX_SOF_LO;
          next_cnt = '0;
          next_inf_cnt = '0;
          next_seg = tntf_pkg::SEG_PCB;
          next_shreg = {1'b1, pcb, 1'b0};
          next_tx_crc = tntf_pkg::tntf_crc_byte(tntf_pkg::CRC_INIT, pcb);
          next_tx_bit = 1'b0;
        end
      end
      tntf_pkg::TX_SOF_LO: begin
        if (etu_end) begin
          next_cnt = cnt + 4'h1;
          if (cnt == tntf_pkg::SOF_LO_ETU - 4'h1) begin
            next_tx_st = tntf_pkg::TX_SOF_HI;
            next_cnt = '0;
            next_tx_bit = 1'b1;
          end
        end
      end
      tntf_pkg::TX_SOF_HI: begin
        if (etu_end) begin
          next_cnt = cnt + 4'h1;
          if (cnt == tntf_pkg::SOF_HI_ETU - 4'h1) begin
            next_tx_st = tntf_pkg::TX_CHAR;
            next_cnt = '0;
            next_tx_bit = shreg[0];
          end
        end
      end
      tntf_pkg::TX_CHAR: begin
        if (etu_end && !char_end) begin
          next_cnt = cnt + 4'h1;
          next_shreg = {1'b1, shreg[9:1]};
          next_tx_bit = shreg[1];
        end
        if (char_end) begin
          next_cnt = '0;
          unique case (seg)
            tntf_pkg::SEG_PCB, tntf_pkg::SEG_HDR, tntf_pkg::SEG_INF: begin
              if (ctrl.resp_write && (seg == tntf_pkg::SEG_PCB ||
                  (seg == tntf_pkg::SEG_HDR && inf_cnt[3:0] != tntf_pkg::HDR_LAST))) begin
                next_seg = tntf_pkg::SEG_HDR;
                next_inf_cnt = seg == tntf_pkg::SEG_PCB ? '0 : inf_cnt + 9'h001;
                if (seg == tntf_pkg::SEG_PCB) begin
                  next_shreg = {1'b1, tntf_pkg::WRITE_RESP_CODE, 1'b0};
                end else if (inf_cnt[3:0] + 4'h1 < tntf_pkg::HDR_FLAG1) begin
                  next_shreg = {1'b1, card_id[8*(8 - int'(inf_cnt[3:0])) - 1 -: 8], 1'b0};
                end else if (inf_cnt[3:0] + 4'h1 == tntf_pkg::HDR_FLAG1) begin
                  next_shreg = {1'b1, flags[15:8], 1'b0};
                end else begin
                  next_shreg = {1'b1, flags[7:0], 1'b0};
                end
              end else if (inf_more) begin
                next_seg = tntf_pkg::SEG_INF;
                next_inf_cnt = seg == tntf_pkg::SEG_PCB ? '0 : inf_cnt + 9'h001;
                fifo_out_ready = 1'b1;
                next_shreg = {1'b1, fifo_out_data, 1'b0};
              end else begin
                next_seg = tntf_pkg::SEG_CRC0;
                next_shreg = {1'b1, ~tx_crc[7:0], 1'b0};
              end
              if (next_seg != tntf_pkg::SEG_CRC0) begin
                next_tx_crc = tntf_pkg::tntf_crc_byte(tx_crc, next_shreg[8:1]);
              end
              next_tx_bit = 1'b0;
            end
            tntf_pkg::SEG_CRC0: begin
              next_seg = tntf_pkg::SEG_CRC1;
              next_shreg = {1'b1, ~tx_crc[15:8], 1'b0};
              next_tx_bit = 1'b0;
            end
            default: begin
              next_tx_st = tntf_pkg::TX_EOF;
              next_tx_bit = 1'b0;
            end
          endcase
        end
      end
      tntf_pkg::TX_EOF: begin
        if (etu_end) begin
          next_cnt = cnt + 4'h1;
          if (cnt == tntf_pkg::EOF_ETU - 4'h1) begin
            next_tx_st = tntf_pkg::TX_IDLE;
            next_tx_bit = 1'b1;
          end
        end
      end
      default: next_tx_st = tntf_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_st <= tntf_pkg::TX_IDLE;
      seg <= tntf_pkg::SEG_PCB;
      etu <= '0;
      cnt <= '0;
      inf_cnt <= '0;
      shreg <= '1;
      tx_crc <= tntf_pkg::CRC_INIT;
      tx_bit <= 1'b1;
      tx_active <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      seg <= next_seg;
      etu <= next_etu;
      cnt <= next_cnt;
      inf_cnt <= next_inf_cnt;
      shreg <= next_shreg;
      tx_crc <= next_tx_crc;
      tx_bit <= next_tx_bit;
      tx_active <= next_tx_st != tntf_pkg::TX_IDLE;
    end
  end

  // Receiver: one bit per strobe, verdict at frame end
  always_comb begin
    next_rx_frame_q = rx_frame;
    next_rcnt = rcnt;
    next_rshift = rshift;
    next_rx_crc = rx_crc;
    next_rx_ferr = rx_ferr;
    next_rx_cur = rx_cur;
    next_rx_last = rx_last;
    next_rx_good = rx_good;
    next_rx_bad = rx_bad;
    if (rx_frame && !rx_frame_q) begin
      next_rcnt = '0;
      next_rx_crc = tntf_pkg::CRC_INIT;
      next_rx_ferr = 1'b0;
      next_rx_cur = '0;
    end else if (rx_frame && rx_stb) begin
      if (rcnt == '0) begin
        next_rcnt = rx_bit ? rcnt : 4'h1;
      end else if (rcnt <= tntf_pkg::DATA_LAST) begin
        next_rshift = {rx_bit, rshift[7:1]};
        next_rcnt = rcnt + 4'h1;
      end else begin
        next_rcnt = '0;
        next_rx_ferr = rx_ferr || !rx_bit || rx_cur.len == tntf_pkg::RX_MAX;
        next_rx_crc = tntf_pkg::tntf_crc_byte(rx_crc, rshift);
        if (rx_cur.len == '0) begin
          next_rx_cur.pcb = rshift;
        end
        if (rx_cur.len != tntf_pkg::RX_MAX) begin
          next_rx_cur.len = rx_cur.len + 9'h001;
        end
      end
    end else if (!rx_frame && rx_frame_q) begin
      next_rx_good = rx_crc == tntf_pkg::CRC_RESIDUE && !rx_ferr &&
                     rx_cur.len >= tntf_pkg::RX_MIN && rcnt == '0;
      next_rx_bad = !next_rx_good;
      if (next_rx_good) begin
        next_rx_last = rx_cur;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_frame_q <= 1'b0;
      rcnt <= '0;
      rshift <= '0;
      rx_crc <= tntf_pkg::CRC_INIT;
      rx_ferr <= 1'b0;
      rx_cur <= '0;
      rx_last <= '0;
      rx_good <= 1'b0;
      rx_bad <= 1'b0;
    end else begin
      rx_frame_q <= next_rx_frame_q;
      rcnt <= next_rcnt;
      rshift <= next_rshift;
      rx_crc <= next_rx_crc;
      rx_ferr <= next_rx_ferr;
      rx_cur <= next_rx_cur;
      rx_last <= next_rx_last;
      rx_good <= next_rx_good;
      rx_bad <= next_rx_bad;
    end
  end
endmodule : tntf_framer
`default_nettype wire

// ===== tntf_framer_assertions.sv
/* Port checker for tntf_framer: bus timing and transmit framing.
 Bound to the framer; sees only its ports, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module tntf_framer_chk #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic tx_bit,
  input wire logic tx_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic rd_req;
  logic rd_q;
  logic next_rd_q;
  assign rd_req = hsel && htrans[1] && hready && !hwrite;
  always_comb begin
    next_rd_q = rd_req;
  end
  always_ff @(posedge clk_sys) begin
    rd_q <= next_rd_q;
  end
  sequence sof_low;
    !tx_bit [*8];
  endsequence
  sequence held_on;
    tx_active [*8];
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not OKAY");
  chk_read_no_wait: assert property (rd_req |=> hreadyout)
    else $error("read stalled");
  chk_write_no_wait: assert property (hsel && htrans[1] && hready && hwrite
    && haddr[7:2] != 6'h02 |=> hreadyout) else $error("write stalled");
  chk_unmapped_zero: assert property (rd_req && haddr[7:2] == 6'h0F |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_stands: assert property (!rd_q |-> $stable(hrdata))
    else $error("read data moved");
  chk_idle_high: assert property (!tx_active |-> tx_bit)
    else $error("line not high when idle");
  chk_sof_low: assert property ($rose(tx_active) |-> ##1 sof_low)
    else $error("start of frame not low");
  chk_frame_held: assert property ($rose(tx_active) |=> held_on)
    else $error("frame ended at once");
  chk_eof_low: assert property ($fell(tx_active) |-> !$past(tx_bit, 2))
    else $error("frame not closed low");
endmodule : tntf_framer_chk
bind tntf_framer tntf_framer_chk #(.FIFO_DEPTH(FIFO_DEPTH)) tntf_framer_chk_i (
  .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .tx_bit(tx_bit), .tx_active(tx_active));
`default_nettype wire

// ===== tntf_framer_tb.sv
/* Self-checking testbench for tntf_framer.
 Assumes tntf_reader on the link side and AHB-Lite single word access. */
`timescale 1ns/1ps
`default_nettype none
module tntf_framer_tb;
  logic clk_sys;
  logic reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic rx_frame;
  logic rx_stb;
  logic rx_bit;
  logic tx_bit;
  logic tx_active;
  logic rdy_n;
  logic [31:0] rd_n;
  int mismatches;
  int total_checks;
  int cycles;
  tntf_framer #(.FIFO_DEPTH(8)) tntf_framer_i (.clk_sys(clk_sys), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .rx_frame(rx_frame), .rx_stb(rx_stb), .rx_bit(rx_bit),
    .tx_bit(tx_bit), .tx_active(tx_active));
  tntf_reader tntf_reader_i (.clk_sys(clk_sys), .tx_bit(tx_bit), .rx_frame(rx_frame),
    .rx_stb(rx_stb), .rx_bit(rx_bit));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Sampled mid-cycle so the edge never races the design
  always @(negedge clk_sys) begin
    rdy_n <= hreadyout;
    rd_n <= hrdata;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 150000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge clk_sys); while (rdy_n !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (rdy_n !== 1'b1);
    q = rd_n;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    cmp(q & m, e);
  endtask : rd_chk
  task automatic t_regs;
    rd_chk(8'h04, 32'h000000FF, 32'h00000048);
    rd_chk(8'h3C, 32'hFFFFFFFF, 32'h00000000);
    rd_chk(8'h00, 32'hFFFFFFFF, 32'h00000000);
  endtask : t_regs
  task automatic t_aib;
    logic [7:0] sel [4] = '{8'h00, 8'h01, 8'h17, 8'h18};
    logic [7:0] exp [4] = '{8'h40, 8'h80, 8'h80, 8'h00};
    wr(8'h20, 32'h000B0F10);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h28, 32'h00010000);
    wr(8'h20, 32'h000B0F10);
    wr(8'h24, 32'h00000017);
    wr(8'h2C, 32'h45000300);
    rd_chk(8'h30, 32'h0000FFFF, 32'h00000045);
    rd_chk(8'h04, 32'h00000018, 32'h00000018);
    wr(8'h2C, 32'h46000300);
    rd_chk(8'h04, 32'h00000008, 32'h00000000);
    wr(8'h28, 32'h00000000);
    wr(8'h20, 32'h00000000);
    rd_chk(8'h20, 32'hFFFFFFFF, 32'h000B0F10);
    rd_chk(8'h04, 32'h00000010, 32'h00000000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h34, {24'h000000, sel[i]});
      rd_chk(8'h04, 32'h000000C0, {24'h000000, exp[i]});
    end
  endtask : t_aib
  task automatic t_rx;
    tntf_reader_i.msg[0] = 8'h02;
    tntf_reader_i.msg[1] = 8'h12;
    tntf_reader_i.msg[2] = 8'hFC;
    tntf_reader_i.send_frame(3, 1'b0);
    rd_chk(8'h04, 32'h00000006, 32'h00000002);
    rd_chk(8'h1C, 32'h01FF00FF, 32'h00050002);
    tntf_reader_i.msg[1] = 8'hD0;
    tntf_reader_i.msg[2] = 8'h00;
    tntf_reader_i.msg[3] = 8'h00;
    tntf_reader_i.send_frame(4, 1'b1);
    rd_chk(8'h04, 32'h00000006, 32'h00000004);
    rd_chk(8'h1C, 32'h01FF00FF, 32'h00050002);
    wr(8'h00, 32'h00000002);
    rd_chk(8'h04, 32'h00000001, 32'h00000000);
    for (int i = 1; i < 255; i++) tntf_reader_i.msg[i] = 8'(i);
    tntf_reader_i.send_frame(255, 1'b0);
    rd_chk(8'h04, 32'h00000006, 32'h00000004);
    tntf_reader_i.send_frame(254, 1'b0);
    rd_chk(8'h1C, 32'h01FF00FF, 32'h01000002);
  endtask : t_rx
  task automatic t_tx;
    logic [7:0] exp [10] = '{8'h0A, 8'h09, 8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hAB,
      8'hCD, 8'hEF};
    wr(8'h18, 32'h0000000A);
    wr(8'h10, 32'h01234567);
    wr(8'h0C, 32'h89ABCDEF);
    wr(8'h14, 32'h00005AA5);
    for (int i = 0; i < 8; i++) wr(8'h08, 32'(i));
    rd_chk(8'h04, 32'h00000020, 32'h00000020);
    fork
      tntf_reader_i.recv(10, 943);
      begin
        wr(8'h00, 32'h00000007);
        rd_chk(8'h04, 32'h00000001, 32'h00000001);
      end
    join
    for (int i = 0; i < 10; i++) cmp({24'h000000, tntf_reader_i.rxq[i]}, {24'h0, exp[i]});
    cmp({31'h0, tntf_reader_i.frame_err}, 32'h00000000);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    cmp({30'h0, tx_active, tx_bit}, 32'h00000001);
    @(posedge clk_sys);
    rd_chk(8'h04, 32'h00000021, 32'h00000000);
  endtask : t_tx
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_aib();
    t_rx();
    t_tx();
    close_out();
  end
endmodule : tntf_framer_tb
`default_nettype wire

// ===== tntf_pkg.sv
/*
 Constants, carrier types and the CRC_B helper for the tag-side
 Type B framer with its NDEF attribute block.
 Assumes a 200 MHz system clock and single-word AHB-Lite access.
*/
`default_nettype none
package tntf_pkg;
  localparam int CLK_NS = 5;
  // 128 carrier cycles at 13.56 MHz, rounded up
  localparam int ETU_NS = 9440;
  localparam int ETU_CYC = (ETU_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [10:0] ETU_LAST = 11'(ETU_CYC - 1);
  localparam logic [10:0] ETU_LAST_FAST = 11'(ETU_CYC / 2 - 1);
  localparam logic [3:0] SOF_LO_ETU = 4'hA;
  localparam logic [3:0] SOF_HI_ETU = 4'h2;
  localparam logic [3:0] EOF_ETU = 4'hA;
  localparam logic [3:0] CHAR_LAST = 4'h9;
  localparam logic [3:0] DATA_LAST = 4'h8;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_ID_LO = 8'h0C;
  localparam logic [7:0] OFS_ID_HI = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_PCB = 8'h18;
  localparam logic [7:0] OFS_RXINFO = 8'h1C;
  localparam logic [7:0] OFS_AIB0 = 8'h20;
  localparam logic [7:0] OFS_AIB3 = 8'h2C;
  localparam logic [7:0] OFS_AIBSUM = 8'h30;
  localparam logic [7:0] OFS_BLKSEL = 8'h34;

  localparam int CTRL_RATE = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_RESP = 2;

  localparam logic [7:0] WRITE_RESP_CODE = 8'h09;
  localparam logic [3:0] HDR_LAST = 4'hA;
  localparam logic [3:0] HDR_FLAG1 = 4'h9;
  localparam logic [8:0] INF_MAX = 9'hFC;
  localparam logic [8:0] RX_MAX = 9'h100;
  localparam logic [8:0] RX_MIN = 9'h003;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;

  localparam int AIB_SUM_LAST = 13;
  localparam int AIB_SUM_HI = 14;
  localparam int AIB_SUM_LO = 15;
  localparam int AIB_RW_BYTE = 10;
  localparam logic [1:0] AIB_RW_WORD = 2'h2;
  localparam logic [7:0] AIB_RW_VALUE = 8'h01;
  localparam logic [7:0] AIB_BLOCK = 8'h00;
  localparam logic [7:0] NDEF_FIRST = 8'h01;
  localparam logic [7:0] NDEF_LAST = 8'h17;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_SOF_LO = 3'b001,
    TX_SOF_HI = 3'b010,
    TX_CHAR = 3'b011,
    TX_EOF = 3'b100
  } tntf_tx_e;

  typedef enum logic [2:0] {
    SEG_PCB = 3'b000,
    SEG_HDR = 3'b001,
    SEG_INF = 3'b010,
    SEG_CRC0 = 3'b011,
    SEG_CRC1 = 3'b100
  } tntf_seg_e;

  typedef struct packed {
    logic resp_write;
    logic rate212;
  } tntf_ctrl_s;

  typedef struct packed {
    logic [8:0] len;
    logic [7:0] pcb;
  } tntf_rxinfo_s;

  function automatic logic [15:0] tntf_crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : tntf_crc_byte
endpackage : tntf_pkg
`default_nettype wire

// ===== tntf_reader.sv
/* Reader model: sends NRZ frames to the tag, decodes its replies.
 Assumes the testbench fills msg and calls the tasks. */
`timescale 1ns/1ps
`default_nettype none
module tntf_reader (
  input wire logic clk_sys,
  input wire logic tx_bit,
  output logic rx_frame,
  output logic rx_stb,
  output logic rx_bit
);
  logic [7:0] msg [0:259];
  logic [7:0] rxq [0:15];
  logic frame_err;
  initial begin
    rx_frame = 1'b0;
    rx_stb = 1'b0;
    rx_bit = 1'b1;
    frame_err = 1'b0;
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 16'h8408 : r >> 1;
    return r;
  endfunction : crc_step
  task automatic send_frame(input int n, input logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) c = crc_step(c, msg[i]);
    c = ~c ^ {12'h000, bad, 3'h0};
    msg[n] = c[7:0];
    msg[n + 1] = c[15:8];
    @(posedge clk_sys) rx_frame <= 1'b1;
    for (int i = 0; i < n + 2; i++) begin
      for (int j = 0; j < 10; j++) begin
        @(posedge clk_sys);
        rx_bit <= (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : msg[i][j - 1];
        rx_stb <= 1'b1;
        @(posedge clk_sys);
        rx_stb <= 1'b0;
        rx_bit <= ~rx_bit;
      end
    end
    @(posedge clk_sys) rx_frame <= 1'b0;
    // Verdict registers one edge after the frame drops
    @(posedge clk_sys);
  endtask : send_frame
  task automatic recv(input int n, input int etu);
    frame_err = 1'b0;
    @(negedge tx_bit);
    repeat (12 * etu + etu / 2) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      for (int j = 0; j < 10; j++) begin
        if (j == 0 && tx_bit !== 1'b0) frame_err = 1'b1;
        if (j == 9 && tx_bit !== 1'b1) frame_err = 1'b1;
        if (j > 0 && j < 9) rxq[i][j - 1] = tx_bit;
        repeat (etu) @(posedge clk_sys);
      end
    end
  endtask : recv
endmodule : tntf_reader
`default_nettype wire
